/* src/fsp_pkg.sv */
/*
  package for the flash security and protection register block: register
  offsets, field positions, reset values and the carrier structs.
  assumes a classic wishbone slave with 32-bit data and byte addressing.
*/
package fsp_pkg;

  // ----------------------------------------------------------------------
  // register offsets (byte addresses, word aligned)
  // ----------------------------------------------------------------------
  localparam logic [7:0] FSP_OFF_CONFIG  = 8'h00; // module_configuration
  localparam logic [7:0] FSP_OFF_SECURE  = 8'h04; // security_word
  localparam logic [7:0] FSP_OFF_PROTECT = 8'h08; // sector_protect_mask
  localparam logic [7:0] FSP_OFF_SUPERVISOR_SPACE_BITS    = 8'h0C; // sector_supervisor_mask
  localparam logic [7:0] FSP_OFF_DATA    = 8'h10; // sector_data_only_mask
  localparam logic [7:0] FSP_OFF_USTAT   = 8'h14; // user_status

  // ----------------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------------
  localparam int FSP_SEC_BACKDOOR_KEY_ENABLE_BIT   = 31;
  localparam int FSP_SEC_STAT_BIT    = 30;
  localparam int FSP_CFG_LOCK_BIT    = 10;
  localparam int FSP_CFG_KEY_ACCESS_CONTROL_BIT  = 5;
  localparam int FSP_ST_BUF_EMPTY    = 7;
  localparam int FSP_ST_CMD_DONE     = 6;
  localparam int FSP_ST_PROT_VIOL    = 5;
  localparam int FSP_ST_ACC_ERR      = 4;
  localparam int FSP_ST_BLANK        = 2;

  // ----------------------------------------------------------------------
  // values
  // ----------------------------------------------------------------------
  localparam logic [15:0] FSP_SECURE_CODE     = 16'h4AC8;
  localparam logic [31:0] FSP_SEC_READ_MASK   = 32'hC000_FFFF;
  localparam logic [7:0]  FSP_USTAT_WR_MASK   = 8'hB4;
  localparam logic [7:0]  FSP_USTAT_RST       = 8'hC0;
  localparam logic [15:0] FSP_CFG_FIELD_OFFS  = 16'h0414;
  localparam int          FSP_SECTORS         = 32;
  localparam int          FSP_SECTOR_BYTES    = 8192;
  localparam int          FSP_SECTOR_LSB      = 13;

  // security word and masks as fetched from the flash configuration field
  typedef struct packed {
    logic [31:0] security;
    logic [31:0] protect;
    logic [31:0] supervisor_space_bits;
    logic [31:0] data_only;
  } fsp_cfg_field_s;

  // status events from the command controller
  typedef struct packed {
    logic buf_empty_set;
    logic cmd_done;
    logic prot_viol_set;
    logic acc_err_set;
    logic blank_set;
    logic buf_empty_clr;
  } fsp_cmd_evt_s;

  // one flash array access to be checked
  typedef struct packed {
    logic        valid;
    logic [17:0] addr;
    logic        supervisor;
    logic        ifetch;
    logic        prog_erase;
  } fsp_acc_s;

endpackage : fsp_pkg

/* src/fsp_top.sv */
/*
  flash security and protection register block: security word, sector
  protect / supervisor / data-only masks, write lock, key access bit and
  user status, with a per-access check of the flash array.
  assumes a classic wishbone master on clk_i and a configuration field
  image presented by the flash reset loader with a one-cycle load strobe.
  sector index width follows NSECT; the masks stay one word wide.
  assertions sit at the end of the module and share its clock and reset.
*/
// Design decisions made here: register access over Wishbone and the placing of the registers.
// Contract
// - security word reads bits 31,30,15:0, writes ignored
// - bit 31 shows backdoor key enable
// - bit 30 shows security in force
// - key and status bits derive from security state
// - security word loaded from field at 0x0414
// - secured only when code equals 0x4AC8
// - thirty-two 8K sectors, bit M is sector M
// - protect bit 1 blocks program and erase
// - protect mask writable only while lock clear
// - masks initialised from configuration field at reset
// - supervisor mask writable only while lock clear
// - supervisor bit 1 makes sector supervisor only
// - data mask writable only while lock clear
// - data bit 1 makes sector data only
// - status flags write one clear, done read only
// - status flags driven on output bits 7:4,2
// - lock readable, sticks set until reset
// - key access writable only with key enable
// - violation flag set on protected program, w1c
// - violation flag blocks command launch
`timescale 1ns/100ps
`default_nettype none

module fsp_top #(
  parameter int NSECT = fsp_pkg::FSP_SECTORS
) (
  input  wire logic                   clk_i,
  input  wire logic                   rst_i,
  // wishbone slave
  input  wire logic                   cyc_i,
  input  wire logic                   stb_i,
  input  wire logic                   we_i,
  input  wire logic [7:0]             adr_i,
  input  wire logic [3:0]             sel_i,
  input  wire logic [31:0]            dat_i,
  output logic      [31:0]            dat_o,
  output logic                        ack_o,
  output logic                        err_o,
  // configuration field image from the reset loader
  input  wire logic                   cfg_load_i,
  input  wire fsp_pkg::fsp_cfg_field_s cfg_field_i,
  // command controller events
  input  wire fsp_pkg::fsp_cmd_evt_s  evt_i,
  // flash array access check
  input  wire fsp_pkg::fsp_acc_s      acc_i,
  output logic                        acc_bus_err_o,
  output logic                        pe_blocked_o,
  output logic                        launch_ok_o,
  output logic                        key_access_o,
  output logic [7:0]                  status_bits_o
);

  // ----------------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------------
  logic [31:0] sec_r;
  logic [31:0] prot_r;
  logic [31:0] supervisor_space_bits_r;
  logic [31:0] data_only_bits_r;
  logic        lock_r;
  logic        key_access_control_r;
  logic [7:0]  ustat_r;
  logic [7:0]  ustat_nxt;
  logic        ack_r;
  logic        err_r;
  logic [31:0] dat_r;
  logic        acc_err_r;
  logic        pe_blk_r;
  logic        launch_r;

  // byte lane merge used by the three sector mask registers
  function automatic logic [31:0] lane_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0]  sel);
    logic [31:0] res;
    res = old_v;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        res[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    return res;
  endfunction

  // ----------------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------------
  wire req     = cyc_i & stb_i & ~ack_r & ~err_r;
  wire hit_cfg = (adr_i == fsp_pkg::FSP_OFF_CONFIG);
  wire hit_sec = (adr_i == fsp_pkg::FSP_OFF_SECURE);
  wire hit_pro = (adr_i == fsp_pkg::FSP_OFF_PROTECT);
  wire hit_sup = (adr_i == fsp_pkg::FSP_OFF_SUPERVISOR_SPACE_BITS);
  wire hit_dat = (adr_i == fsp_pkg::FSP_OFF_DATA);
  wire hit_ust = (adr_i == fsp_pkg::FSP_OFF_USTAT);
  wire mapped  = hit_cfg | hit_sec | hit_pro | hit_sup | hit_dat | hit_ust;
  wire wr      = req & we_i & mapped;
  wire mask_wr = wr & ~lock_r;

  // security state decode
  wire secured   = (sec_r[15:0] == fsp_pkg::FSP_SECURE_CODE);
  wire [31:0] sec_view = sec_r & fsp_pkg::FSP_SEC_READ_MASK;

  // configuration register image (lock and key access bits only)
  wire [31:0] cfg_view = ({31'h0000_0000, lock_r} << fsp_pkg::FSP_CFG_LOCK_BIT)
                       | ({31'h0000_0000, key_access_control_r} << fsp_pkg::FSP_CFG_KEY_ACCESS_CONTROL_BIT);

  // read mux
  wire [31:0] rd_mux = hit_cfg ? cfg_view :
                       hit_sec ? sec_view :
                       hit_pro ? prot_r :
                       hit_sup ? supervisor_space_bits_r :
                       hit_dat ? data_only_bits_r :
                       hit_ust ? {24'h00_0000, ustat_r} : 32'h0000_0000;

  // ----------------------------------------------------------------------
  // access check of the flash array
  // ----------------------------------------------------------------------
  localparam int SECT_W = $clog2(NSECT);
  wire [SECT_W-1:0] sect = acc_i.addr[fsp_pkg::FSP_SECTOR_LSB +: SECT_W];
  wire prot_hit     = acc_i.valid & acc_i.prog_erase & prot_r[sect];
  wire supervisor_space_bits_viol    = acc_i.valid & supervisor_space_bits_r[sect] & ~acc_i.supervisor;
  wire fetch_viol   = acc_i.valid & data_only_bits_r[sect] & acc_i.ifetch;

  // ----------------------------------------------------------------------
  // user status next value: set wins over write-one clear, buf_empty_clr over buf_empty_set
  // ----------------------------------------------------------------------
  wire [7:0] w1c = (wr & hit_ust & sel_i[0]) ? (dat_i[7:0] & fsp_pkg::FSP_USTAT_WR_MASK)
                                             : 8'h00;
  always_comb begin
    ustat_nxt = ustat_r & ~w1c;
    if (evt_i.buf_empty_set) ustat_nxt[fsp_pkg::FSP_ST_BUF_EMPTY] = 1'b1;
    if (evt_i.buf_empty_clr) ustat_nxt[fsp_pkg::FSP_ST_BUF_EMPTY] = 1'b0;
    ustat_nxt[fsp_pkg::FSP_ST_CMD_DONE] = evt_i.cmd_done;
    if (evt_i.prot_viol_set | prot_hit)
      ustat_nxt[fsp_pkg::FSP_ST_PROT_VIOL] = 1'b1;
    if (evt_i.acc_err_set) ustat_nxt[fsp_pkg::FSP_ST_ACC_ERR] = 1'b1;
    if (evt_i.blank_set)   ustat_nxt[fsp_pkg::FSP_ST_BLANK] = 1'b1;
    ustat_nxt[3] = 1'b0;
    ustat_nxt[1:0] = 2'b00;
  end

  // ----------------------------------------------------------------------
  // bus answer: one cycle after the request, ack or err
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
      err_r <= 1'b0;
      dat_r <= 32'h0000_0000;
    end else begin
      ack_r <= req & mapped;
      err_r <= req & ~mapped;                                  // unmapped address
      dat_r <= (req & ~we_i) ? rd_mux : 32'h0000_0000;
    end
  end

  // security word, loaded only from the configuration field
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sec_r <= 32'h0000_0000;
    end else if (cfg_load_i) begin
      sec_r[15:0] <= cfg_field_i.security[15:0];
      sec_r[fsp_pkg::FSP_SEC_BACKDOOR_KEY_ENABLE_BIT] <= cfg_field_i.security[fsp_pkg::FSP_SEC_BACKDOOR_KEY_ENABLE_BIT];
      sec_r[fsp_pkg::FSP_SEC_STAT_BIT] <= (cfg_field_i.security[15:0] == fsp_pkg::FSP_SECURE_CODE);
    end
  end

  // sector masks: loaded from the field, then lock-gated writes
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      prot_r <= 32'h0000_0000;
      supervisor_space_bits_r <= 32'h0000_0000;
      data_only_bits_r <= 32'h0000_0000;
    end else if (cfg_load_i) begin
      prot_r <= cfg_field_i.protect;
      supervisor_space_bits_r <= cfg_field_i.supervisor_space_bits;
      data_only_bits_r <= cfg_field_i.data_only;
    end else begin
      if (mask_wr & hit_pro) prot_r <= lane_merge(prot_r, dat_i, sel_i);
      if (mask_wr & hit_sup) supervisor_space_bits_r <= lane_merge(supervisor_space_bits_r, dat_i, sel_i);
      if (mask_wr & hit_dat) data_only_bits_r <= lane_merge(data_only_bits_r, dat_i, sel_i);
    end
  end

  // lock sticks once set; key access needs the key enable
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lock_r   <= 1'b0;
      key_access_control_r <= 1'b0;
    end else if (wr & hit_cfg) begin
      if (sel_i[1] & dat_i[fsp_pkg::FSP_CFG_LOCK_BIT]) lock_r <= 1'b1;
      if (sel_i[0] & sec_r[fsp_pkg::FSP_SEC_BACKDOOR_KEY_ENABLE_BIT])
        key_access_control_r <= dat_i[fsp_pkg::FSP_CFG_KEY_ACCESS_CONTROL_BIT];
    end
  end

  // status register and derived outputs
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ustat_r   <= fsp_pkg::FSP_USTAT_RST;
      acc_err_r <= 1'b0;
      pe_blk_r  <= 1'b0;
      launch_r  <= 1'b0;
    end else begin
      ustat_r   <= ustat_nxt;
      acc_err_r <= supervisor_space_bits_viol | fetch_viol;
      pe_blk_r  <= prot_hit;
      launch_r  <= ~ustat_nxt[fsp_pkg::FSP_ST_PROT_VIOL]
                 & ~ustat_nxt[fsp_pkg::FSP_ST_ACC_ERR];
    end
  end

  assign dat_o         = dat_r;
  assign ack_o         = ack_r;
  assign err_o         = err_r;
  assign acc_bus_err_o = acc_err_r;
  assign pe_blocked_o  = pe_blk_r;
  assign launch_ok_o   = launch_r;
  assign key_access_o  = key_access_control_r;
  assign status_bits_o = ustat_r;

  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_locked_write;
    lock_r && req && we_i && (hit_pro || hit_sup || hit_dat) && !cfg_load_i;
  endsequence

  // full-word write to an open mask register, not shadowed by a field load
  sequence s_open_write(hit);
    !lock_r && req && we_i && hit && (sel_i == 4'hF) && !cfg_load_i;
  endsequence

  // read taken on this edge and answered on the next
  sequence s_read_taken(hit);
    req && !we_i && hit ##1 ack_o;
  endsequence

  // security view, lock and key gates, violation and fault outputs
  a_sec_read_mask: assert property (ack_r && $past(hit_sec && !we_i) |->
    (dat_o & ~fsp_pkg::FSP_SEC_READ_MASK) == 32'h0) else $error("security reserved bits nonzero");
  a_sec_no_write: assert property (!cfg_load_i |=> $stable(sec_r))
    else $error("security word changed without load");
  a_sec_status: assert property (sec_r[fsp_pkg::FSP_SEC_STAT_BIT] == secured)
    else $error("security status mismatch");
  a_mask_locked: assert property (s_locked_write |=>
    $stable(prot_r) && $stable(supervisor_space_bits_r) && $stable(data_only_bits_r))
    else $error("mask written while locked");
  a_lock_sticky: assert property (lock_r |=> lock_r)
    else $error("lock cleared");
  a_key_gate: assert property (!sec_r[fsp_pkg::FSP_SEC_BACKDOOR_KEY_ENABLE_BIT] |=> $stable(key_access_control_r))
    else $error("key access changed without enable");
  a_viol_set: assert property (prot_hit |=> ustat_r[fsp_pkg::FSP_ST_PROT_VIOL] && pe_blocked_o)
    else $error("violation flag not set");
  a_launch_block: assert property (ustat_r[fsp_pkg::FSP_ST_PROT_VIOL] |-> !launch_ok_o)
    else $error("launch allowed during violation");
  a_bus_fault: assert property (supervisor_space_bits_viol |=> acc_bus_err_o)
    else $error("user access not faulted");

  // one answer per request, err for holes in the map
  a_ack_one: assert property (req && mapped |=> ack_o ##1 !ack_o)
    else $error("ack timing wrong");
  a_err_unmapped: assert property (req && !mapped |=> err_o && !ack_o)
    else $error("unmapped access not answered with err");

  // security word and masks take the field image of a load
  a_key_load: assert property (cfg_load_i |=>
    sec_r[fsp_pkg::FSP_SEC_BACKDOOR_KEY_ENABLE_BIT] == $past(cfg_field_i.security[fsp_pkg::FSP_SEC_BACKDOOR_KEY_ENABLE_BIT]))
    else $error("key enable not copied");
  a_code_load: assert property (cfg_load_i |=>
    sec_r[15:0] == $past(cfg_field_i.security[15:0]))
    else $error("security code not loaded");
  a_stat_load: assert property (cfg_load_i |=>
    sec_r[fsp_pkg::FSP_SEC_STAT_BIT] == ($past(cfg_field_i.security[15:0]) == fsp_pkg::FSP_SECURE_CODE))
    else $error("security status not derived from code");
  a_mask_load: assert property (cfg_load_i |=> prot_r == $past(cfg_field_i.protect)
    && supervisor_space_bits_r == $past(cfg_field_i.supervisor_space_bits) && data_only_bits_r == $past(cfg_field_i.data_only))
    else $error("masks not loaded from field");

  // open masks take a full-word write and stay readable
  a_prot_write: assert property (s_open_write(hit_pro) |=> prot_r == $past(dat_i))
    else $error("protect mask write lost");
  a_supervisor_space_bits_write: assert property (s_open_write(hit_sup) |=> supervisor_space_bits_r == $past(dat_i))
    else $error("supervisor mask write lost");
  a_data_only_bits_write: assert property (s_open_write(hit_dat) |=> data_only_bits_r == $past(dat_i))
    else $error("data mask write lost");
  a_prot_read: assert property (s_read_taken(hit_pro) |-> dat_o == $past(prot_r))
    else $error("protect mask read wrong");
  a_supervisor_space_bits_read: assert property (s_read_taken(hit_sup) |-> dat_o == $past(supervisor_space_bits_r))
    else $error("supervisor mask read wrong");
  a_data_only_bits_read: assert property (s_read_taken(hit_dat) |-> dat_o == $past(data_only_bits_r))
    else $error("data mask read wrong");

  // lock sets from a config write, key access needs the key enable
  a_lock_set: assert property (req && we_i && hit_cfg && sel_i[1]
    && dat_i[fsp_pkg::FSP_CFG_LOCK_BIT] |=> lock_r)
    else $error("lock not set by write");
  a_key_write: assert property (req && we_i && hit_cfg && sel_i[0]
    && sec_r[fsp_pkg::FSP_SEC_BACKDOOR_KEY_ENABLE_BIT] |=> key_access_o == $past(dat_i[fsp_pkg::FSP_CFG_KEY_ACCESS_CONTROL_BIT]))
    else $error("key access write lost");

  // array accesses: only protected sectors block, supervisor accesses fault only on fetches from data sectors
  a_prot_free: assert property (acc_i.valid && acc_i.prog_erase && !prot_r[sect] |=> !pe_blocked_o)
    else $error("program blocked on open sector");
  a_supervisor_space_bits_ok: assert property (acc_i.valid && acc_i.supervisor && !fetch_viol |=> !acc_bus_err_o)
    else $error("supervisor access faulted");
  a_fetch_fault: assert property (fetch_viol |=> acc_bus_err_o)
    else $error("fetch from data sector not faulted");

  // status flags: hardware set wins, write one clears, done follows the controller
  a_viol_wins: assert property (evt_i.prot_viol_set |=> ustat_r[fsp_pkg::FSP_ST_PROT_VIOL])
    else $error("violation set lost to clear");
  a_viol_clear: assert property (wr && hit_ust && sel_i[0] && dat_i[fsp_pkg::FSP_ST_PROT_VIOL]
    && !evt_i.prot_viol_set && !prot_hit |=> !ustat_r[fsp_pkg::FSP_ST_PROT_VIOL])
    else $error("violation flag not cleared by one");
  a_done_follow: assert property (1'b1 |=>
    ustat_r[fsp_pkg::FSP_ST_CMD_DONE] == $past(evt_i.cmd_done))
    else $error("done flag not following controller");
  a_status_rsvd: assert property (
    (status_bits_o & ~(fsp_pkg::FSP_USTAT_RST | fsp_pkg::FSP_USTAT_WR_MASK)) == 8'h00)
    else $error("reserved status bits set");
  a_launch_acc: assert property (ustat_r[fsp_pkg::FSP_ST_ACC_ERR] |-> !launch_ok_o)
    else $error("launch allowed during access error");

endmodule // fsp_top

`default_nettype wire

/* tb/fsp_cpu_model.sv */
/*
  processor core model: classic wishbone master for the register block.
  assumes a registered slave that answers with ack or err after taking.
*/
`timescale 1ns/100ps
`default_nettype none

module fsp_cpu_model (
  input  wire logic        clk_i,
  input  wire logic        ack_i,
  input  wire logic        err_i,
  input  wire logic [31:0] dat_i,
  output logic             cyc_o,
  output logic             stb_o,
  output logic             we_o,
  output logic      [7:0]  adr_o,
  output logic      [3:0]  sel_o,
  output logic      [31:0] dat_o
);
  // idle bus at time zero
  initial begin
    {cyc_o, stb_o, we_o, adr_o, sel_o, dat_o} = '0;
  end

  // one single cycle, held until ack or err is sampled high
  task automatic access(input logic w, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] q, output logic be);
    @(posedge clk_i);
    cyc_o <= 1'b1;
    stb_o <= 1'b1;
    we_o  <= w;
    adr_o <= a;
    sel_o <= 4'hF;
    dat_o <= d;
    do begin
      @(posedge clk_i);
    end while (!(ack_i | err_i));
    q = dat_i;
    be = err_i;
    // release; parked write data is inverted so stale data never matches
    cyc_o <= 1'b0;
    stb_o <= 1'b0;
    dat_o <= ~d;
  endtask
endmodule // fsp_cpu_model

`default_nettype wire

/* tb/testbench.sv */
/*
  self-checking bench for the flash security register block.
  assumes the cpu model for bus cycles; loader and events driven here.
*/
`timescale 1ns/100ps
`default_nettype none

module testbench;
  logic clk, rst, cfg_load, ack, err, pe_blk, launch_ok, key_acc, acc_berr, cyc, stb, we, be;
  logic [7:0] adr, status, exp_st;
  logic [3:0] sel;
  logic [31:0] wdat, rdat, q;
  fsp_pkg::fsp_cfg_field_s field;
  fsp_pkg::fsp_cmd_evt_s evt;
  fsp_pkg::fsp_acc_s acc;
  int mismatches, total_checks, cycles;
  logic [7:0] offs[3] = '{fsp_pkg::FSP_OFF_PROTECT, fsp_pkg::FSP_OFF_SUPERVISOR_SPACE_BITS, fsp_pkg::FSP_OFF_DATA};
  logic [5:0] evt_tab[4] = '{6'h30, 6'h18, 6'h14, 6'h12};
  logic [7:0] flag_tab[4] = '{8'h80, 8'h20, 8'h10, 8'h04};

  fsp_top i_dut (.clk_i(clk), .rst_i(rst), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
    .sel_i(sel), .dat_i(wdat), .dat_o(rdat), .ack_o(ack), .err_o(err), .cfg_load_i(cfg_load),
    .cfg_field_i(field), .evt_i(evt), .acc_i(acc), .acc_bus_err_o(acc_berr),
    .pe_blocked_o(pe_blk), .launch_ok_o(launch_ok), .key_access_o(key_acc), .status_bits_o(status));

  fsp_cpu_model i_cpu (.clk_i(clk), .ack_i(ack), .err_i(err), .dat_i(rdat), .cyc_o(cyc),
    .stb_o(stb), .we_o(we), .adr_o(adr), .sel_o(sel), .dat_o(wdat));

  // ----------------------------------------------------------------------
  // clock, timeout and helpers
  // ----------------------------------------------------------------------
  always #5 clk = ~clk;

  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      mismatches++;
      print_verdict();
    end
  end

  task automatic print_verdict();
    if (mismatches == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    i_cpu.access(1'b0, a, 32'h0, q, be);
    check(q, exp);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    i_cpu.access(1'b1, a, d, q, be);
    #1;
  endtask

  // one-cycle loader strobe with the whole field image
  task automatic load(input logic [127:0] f);
    @(posedge clk);
    field <= f;
    cfg_load <= 1'b1;
    @(posedge clk);
    cfg_load <= 1'b0;
  endtask

  // one array access, outputs judged one cycle after it is driven
  task automatic acc_chk(input logic [17:0] a, input logic [2:0] kind, input logic [1:0] exp);
    @(posedge clk);
    acc <= {1'b1, a, kind};
    @(posedge clk);
    acc.valid <= 1'b0;
    #1;
    check(32'({pe_blk, acc_berr}), 32'(exp));
  endtask

  task automatic evt_pulse(input logic [5:0] e);
    @(posedge clk);
    evt <= e;
    @(posedge clk);
    evt <= 6'h10;
    #1;
  endtask

  // ----------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------
  initial begin
    {clk, rst, cfg_load, field, acc, mismatches, total_checks, cycles} = '0;
    rst = 1'b1;
    evt = 6'h10;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    #1;
    check(32'(status), 32'hC0);
    load({32'h7FFF_4AC9, 32'h5, 32'h2, 32'h8000_0000});
    rd(fsp_pkg::FSP_OFF_SECURE, 32'h0000_4AC9);
    wr(fsp_pkg::FSP_OFF_CONFIG, 32'h20);
    check(32'(key_acc), 32'h0);
    load({32'h9234_4AC8, 32'h5, 32'h2, 32'h8000_0000});
    rd(fsp_pkg::FSP_OFF_SECURE, 32'hC000_4AC8);
    wr(fsp_pkg::FSP_OFF_SECURE, 32'h0);
    rd(fsp_pkg::FSP_OFF_SECURE, 32'hC000_4AC8);
    wr(fsp_pkg::FSP_OFF_CONFIG, 32'h20);
    check(32'(key_acc), 32'h1);
    rd(fsp_pkg::FSP_OFF_PROTECT, 32'h5);
    rd(fsp_pkg::FSP_OFF_SUPERVISOR_SPACE_BITS, 32'h2);
    rd(fsp_pkg::FSP_OFF_DATA, 32'h8000_0000);
    acc_chk(18'h00000, 3'b101, 2'b10);
    acc_chk(18'h02000, 3'b101, 2'b00);
    acc_chk(18'h04000, 3'b101, 2'b10);
    acc_chk(18'h02000, 3'b000, 2'b01);
    acc_chk(18'h02000, 3'b100, 2'b00);
    acc_chk(18'h3E000, 3'b110, 2'b01);
    acc_chk(18'h3C000, 3'b110, 2'b00);
    check(32'(status), 32'hE0);
    check(32'(launch_ok), 32'h0);
    // lock is clear here, so the masks take the new patterns
    for (int i = 0; i < 3; i++) begin
      wr(offs[i], 32'hA5A5_0000 ^ i);
      rd(offs[i], 32'hA5A5_0000 ^ i);
    end
    wr(fsp_pkg::FSP_OFF_CONFIG, 32'h420);
    rd(fsp_pkg::FSP_OFF_CONFIG, 32'h420);
    for (int i = 0; i < 3; i++) begin
      wr(offs[i], 32'hFFFF_FFFF);
      rd(offs[i], 32'hA5A5_0000 ^ i);
    end
    wr(fsp_pkg::FSP_OFF_CONFIG, 32'h0);
    rd(fsp_pkg::FSP_OFF_CONFIG, 32'h400);
    // second reset in mid-run: lock falls, masks come from a reprogrammed field
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    #1;
    check(32'(status), 32'hC0);
    rd(fsp_pkg::FSP_OFF_CONFIG, 32'h0);
    load({32'h0000_1234, 32'h0000_00F0, 32'h0F00_0000, 32'h0000_0001});
    rd(fsp_pkg::FSP_OFF_SECURE, 32'h0000_1234);
    rd(fsp_pkg::FSP_OFF_PROTECT, 32'h0000_00F0);
    rd(fsp_pkg::FSP_OFF_SUPERVISOR_SPACE_BITS, 32'h0F00_0000);
    rd(fsp_pkg::FSP_OFF_DATA, 32'h0000_0001);
    exp_st = 8'hC0;
    for (int i = 0; i < 4; i++) begin
      evt_pulse(evt_tab[i]);
      exp_st |= flag_tab[i];
      check(32'(status), 32'(exp_st));
      check(32'(launch_ok), 32'(!(exp_st[5] | exp_st[4])));
      wr(fsp_pkg::FSP_OFF_USTAT, 32'(flag_tab[i])); // one flag per write
      exp_st &= ~flag_tab[i];
      check(32'(status), 32'(exp_st));
      check(32'(launch_ok), 32'h1);
    end
    @(posedge clk);
    evt <= 6'h00;
    wr(fsp_pkg::FSP_OFF_USTAT, 32'h40);
    rd(fsp_pkg::FSP_OFF_USTAT, 32'h0);
    i_cpu.access(1'b0, 8'h18, 32'h0, q, be);
    check(32'(be), 32'h1);
    print_verdict();
  end
endmodule // testbench

`default_nettype wire
